/* File: common/lnc_pkg.sv */
// Shared constants for the node configuration and bit-rate block.
// Assumes one system clock and byte-wide register strobes from the core.
package lnc_pkg;
	// Direct mode register fields
	localparam int CFG_ACTIVE_BIT = 7;
	localparam int CFG_MASTER_BIT = 6;
	localparam int CFG_AUTO_BIT = 5;
	// Indirect register indices
	localparam logic [7:0] IDX_DATA_LAST = 8'h07;
	localparam logic [7:0] IDX_CTRL = 8'h08;
	localparam logic [7:0] IDX_STATUS = 8'h09;
	localparam logic [7:0] IDX_SIZE = 8'h0b;
	localparam logic [7:0] IDX_DIV = 8'h0c;
	localparam logic [7:0] IDX_MUL = 8'h0d;
	localparam logic [7:0] IDX_ID = 8'h0e;
	// Frame control fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_RST_ERR_BIT = 2;
	localparam int CTRL_RST_INT_BIT = 3;
	localparam int CTRL_TXRX_BIT = 5;
	// Frame length and checksum fields
	localparam int SIZE_ENH_BIT = 7;
	localparam logic [3:0] LEN_MAX = 4'h8;
	localparam logic [3:0] LEN_ZERO = 4'h0;
	// Prescale and multiply fields
	localparam int MUL_PRE_MSB = 7;
	localparam int MUL_PRE_LSB = 6;
	localparam int MUL_MULT_MSB = 5;
	localparam int MUL_MULT_LSB = 1;
	localparam int MUL_DIV8_BIT = 0;
	// Status fields
	localparam int ST_DONE_BIT = 0;
	localparam int ST_CSERR_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam int ST_RNGERR_BIT = 3;
	localparam int ST_IRQ_BIT = 4;
	localparam int ST_BUSY_BIT = 7;
	// Factor limits
	localparam logic [8:0] DIV_MIN = 9'h0c8;
	localparam logic [8:0] DIV_MAX = 9'h1ff;
	localparam int BAUD_CNT_W = 19;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] REG_RESET = 8'h00;
	typedef enum logic [4:0] {
		LNC_IDLE = 5'b00001,
		LNC_WAIT = 5'b00010,
		LNC_START = 5'b00100,
		LNC_DATA = 5'b01000,
		LNC_STOP = 5'b10000
	} lnc_state_t;
endpackage

/* File: logic/lnc_baud_gen.sv */
// Bit period generator from prescale, divide and multiply factors.
// Assumes factors stay stable while run is high.
`timescale 1ns/1ps
`default_nettype none
module lnc_baud_gen #(
	parameter int CNT_W = lnc_pkg::BAUD_CNT_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Factors
	input wire logic [1:0] prescale,
	input wire logic [4:0] multiply,
	input wire logic [8:0] divide,
	// Control
	input wire logic run,
	input wire logic restart,
	// Timing outputs
	output logic bit_tick,
	output logic mid_tick,
	output logic factor_ok
);
	import lnc_pkg::*;
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} lnc_bg_state_t;
	lnc_bg_state_t s_ff, nxt_s;
	logic [14:0] div_mul;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] gap_ff;
	logic gap_ok_ff;

	always_comb
	begin
		div_mul = 15'(divide) * (15'(multiply) + 15'h0001);
		period = CNT_W'(div_mul) << (3'({1'b0, prescale}) + 3'h1);
		factor_ok = (divide >= DIV_MIN) && (divide <= DIV_MAX);
		nxt_s = s_ff;
		bit_tick = 1'b0;
		mid_tick = run && !restart && (s_ff.cnt == (period >> 1));
		if (restart || !run)
			nxt_s.cnt = '0;
		else if (s_ff.cnt == period - CNT_W'(1))
		begin
			nxt_s.cnt = '0;
			bit_tick = 1'b1;
		end
		else
			nxt_s.cnt = s_ff.cnt + CNT_W'(1);
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	// Cycles since last tick, for checking the period
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			gap_ff <= '0;
			gap_ok_ff <= 1'b0;
		end
		else if (restart || !run)
		begin
			gap_ff <= '0;
			gap_ok_ff <= 1'b0;
		end
		else if (bit_tick)
		begin
			gap_ff <= '0;
			gap_ok_ff <= 1'b1;
		end
		else
			gap_ff <= gap_ff + CNT_W'(1);
	end

	AST_PERIOD: assert property (@(posedge clock) disable iff (sys_rst)
		bit_tick && gap_ok_ff |-> gap_ff + CNT_W'(1) == period)
		else $error("bit period differs from factor product");
	AST_TICK_GAP: assert property (@(posedge clock) disable iff (sys_rst)
		bit_tick && factor_ok |=> !bit_tick [*8])
		else $error("bit ticks too close together");
endmodule
`default_nettype wire

/* File: logic/lnc_top.sv */
// Node configuration, bit-rate setup and frame streaming engine.
// Assumes core strobes are one-cycle pulses and the bus pin is synchronous.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Mode bit 6 set selects master
// - Mode bit 5 selects automatic rate
// - Bit period is prescale, divider, multiplier product
// - Factors limited: prescale 0-3, multiply 0-31, divide 200-511
// - Other registers reached via index and window
// - Mode write with top bit activates interface
// - Index 0x0D: prescale, multiply, divider bit 8
// - Index 0x0C holds divider low byte
// - Index 0x0B bit 7 selects enhanced checksum
// - Control write 0x0C clears errors, interrupt
// - State machine serializes bytes onto bus
// - Data registers hold sent and received bytes
// - Status readable for polling or interrupts
module lnc_top (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Direct mode register
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	// Index register
	input wire logic idx_wr,
	input wire logic [7:0] idx_wdata,
	output logic [7:0] idx_rdata,
	// Data window
	input wire logic win_wr,
	input wire logic [7:0] win_wdata,
	output logic [7:0] win_rdata,
	// Bus pins
	input wire logic lin_rx,
	output logic lin_tx,
	// Status
	output logic irq_req,
	output logic busy
);
	import lnc_pkg::*;
	typedef struct packed {
		lnc_state_t st;
		logic active;
		logic master;
		logic auto_rate;
		logic [7:0] idx;
		logic txrx;
		logic [7:0] size;
		logic [7:0] div_lo;
		logic [7:0] mul;
		logic [7:0] id;
		logic [7:0][7:0] data;
		logic done;
		logic cs_err;
		logic rng_err;
		logic irq;
		logic txd;
		logic rx_prev;
		logic dir_tx;
		logic [7:0] shreg;
		logic [2:0] bitn;
		logic [3:0] bytn;
		logic [7:0] sum;
		logic [7:0] rdata;
	} lnc_top_state_t;
	lnc_top_state_t s_ff, nxt_s;
	logic bit_tick, mid_tick, factor_ok, restart, run;
	logic start_req, clr_err, clr_int, done_ev, err_ev, byte_done, tx_now;
	logic [3:0] len;
	logic [7:0] cur_byte, new_sum, status;
	logic [4:0] mult_eff;

	function automatic logic [7:0] lnc_addc(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] t;
		t = {1'b0, a} + {1'b0, b};
		return t[7:0] + {7'h00, t[8]};
	endfunction

	// Automatic rate uses prescale and divider only
	assign mult_eff = s_ff.auto_rate ? 5'h00 : s_ff.mul[MUL_MULT_MSB:MUL_MULT_LSB];
	assign run = (s_ff.st != LNC_IDLE) && (s_ff.st != LNC_WAIT);

	lnc_baud_gen #(.CNT_W(BAUD_CNT_W)) u_baud (
		.clock(clock),
		.sys_rst(sys_rst),
		.prescale(s_ff.mul[MUL_PRE_MSB:MUL_PRE_LSB]),
		.multiply(mult_eff),
		.divide({s_ff.mul[MUL_DIV8_BIT], s_ff.div_lo}),
		.run(run),
		.restart(restart),
		.bit_tick(bit_tick),
		.mid_tick(mid_tick),
		.factor_ok(factor_ok)
	);

	always_comb
	begin
		len = s_ff.size[3:0];
		if (len == LEN_ZERO || len > LEN_MAX)
			len = LEN_MAX;
		cur_byte = s_ff.dir_tx ? s_ff.data[s_ff.bytn[2:0]] : s_ff.shreg;
		new_sum = lnc_addc(s_ff.sum, cur_byte);
		status = '0;
		status[ST_DONE_BIT] = s_ff.done;
		status[ST_CSERR_BIT] = s_ff.cs_err;
		status[ST_ERR_BIT] = s_ff.cs_err | s_ff.rng_err;
		status[ST_RNGERR_BIT] = s_ff.rng_err;
		status[ST_IRQ_BIT] = s_ff.irq;
		status[ST_BUSY_BIT] = s_ff.st != LNC_IDLE;
	end

	always_comb
	begin
		nxt_s = s_ff;
		start_req = 1'b0;
		clr_err = 1'b0;
		clr_int = 1'b0;
		done_ev = 1'b0;
		err_ev = 1'b0;
		byte_done = 1'b0;
		restart = 1'b0;
		tx_now = s_ff.txrx;
		nxt_s.rx_prev = lin_rx;
		if (cfg_wr)
		begin
			nxt_s.active = s_ff.active | cfg_wdata[CFG_ACTIVE_BIT];
			nxt_s.master = cfg_wdata[CFG_MASTER_BIT];
			nxt_s.auto_rate = cfg_wdata[CFG_AUTO_BIT];
		end
		if (idx_wr)
			nxt_s.idx = idx_wdata;
		if (win_wr)
		begin
			if (s_ff.idx <= IDX_DATA_LAST)
				nxt_s.data[s_ff.idx[2:0]] = win_wdata;
			else
				case (s_ff.idx)
					IDX_CTRL:
					begin
						nxt_s.txrx = win_wdata[CTRL_TXRX_BIT];
						tx_now = win_wdata[CTRL_TXRX_BIT];
						start_req = win_wdata[CTRL_START_BIT];
						clr_err = win_wdata[CTRL_RST_ERR_BIT];
						clr_int = win_wdata[CTRL_RST_INT_BIT];
					end
					IDX_SIZE: nxt_s.size = win_wdata;
					IDX_DIV: nxt_s.div_lo = win_wdata;
					IDX_MUL: nxt_s.mul = win_wdata;
					IDX_ID: nxt_s.id = win_wdata;
					default: ;
				endcase
		end
		if (clr_err)
		begin
			nxt_s.cs_err = 1'b0;
			nxt_s.rng_err = 1'b0;
		end
		if (clr_int)
		begin
			nxt_s.irq = 1'b0;
			nxt_s.done = 1'b0;
		end
		// Frame engine; events below override the clears above
		unique case (s_ff.st)
			LNC_IDLE:
			begin
				nxt_s.txd = 1'b1;
				if (start_req && s_ff.active)
				begin
					if (!factor_ok)
					begin
						nxt_s.rng_err = 1'b1;
						err_ev = 1'b1;
					end
					else
					begin
						nxt_s.bytn = '0;
						nxt_s.sum = s_ff.size[SIZE_ENH_BIT] ? s_ff.id : REG_RESET;
						nxt_s.dir_tx = tx_now;
						nxt_s.shreg = s_ff.data[0];
						if (tx_now)
						begin
							nxt_s.st = LNC_START;
							nxt_s.txd = 1'b0;
							restart = 1'b1;
						end
						else
							nxt_s.st = LNC_WAIT;
					end
				end
			end
			LNC_WAIT:
				if (s_ff.rx_prev && !lin_rx)
				begin
					restart = 1'b1;
					nxt_s.st = LNC_START;
				end
			LNC_START:
				if (!s_ff.dir_tx && mid_tick && lin_rx)
					nxt_s.st = LNC_WAIT;
				else if (bit_tick)
				begin
					nxt_s.st = LNC_DATA;
					nxt_s.bitn = '0;
					if (s_ff.dir_tx)
						nxt_s.txd = s_ff.shreg[0];
				end
			LNC_DATA:
			begin
				if (!s_ff.dir_tx && mid_tick)
					nxt_s.shreg = {lin_rx, s_ff.shreg[7:1]};
				if (bit_tick)
				begin
					nxt_s.bitn = s_ff.bitn + 3'h1;
					if (s_ff.dir_tx)
					begin
						nxt_s.shreg = s_ff.shreg >> 1;
						nxt_s.txd = s_ff.shreg[1];
					end
					if (s_ff.bitn == BIT_LAST)
					begin
						nxt_s.st = LNC_STOP;
						nxt_s.txd = 1'b1;
					end
				end
			end
			LNC_STOP:
				byte_done = s_ff.dir_tx ? bit_tick : mid_tick;
			default: nxt_s.st = LNC_IDLE;
		endcase
		if (byte_done)
		begin
			if (!s_ff.dir_tx && !lin_rx)
			begin
				nxt_s.cs_err = 1'b1;
				err_ev = 1'b1;
				nxt_s.st = LNC_IDLE;
			end
			else if (s_ff.bytn == len)
			begin
				nxt_s.st = LNC_IDLE;
				if (!s_ff.dir_tx && s_ff.shreg != ~s_ff.sum)
				begin
					nxt_s.cs_err = 1'b1;
					err_ev = 1'b1;
				end
				else
					done_ev = 1'b1;
			end
			else
			begin
				nxt_s.sum = new_sum;
				nxt_s.bytn = s_ff.bytn + 4'h1;
				if (!s_ff.dir_tx)
				begin
					nxt_s.data[s_ff.bytn[2:0]] = s_ff.shreg;
					nxt_s.st = LNC_WAIT;
				end
				else
				begin
					nxt_s.shreg = (s_ff.bytn + 4'h1 == len) ? ~new_sum : s_ff.data[3'(s_ff.bytn + 4'h1)];
					nxt_s.st = LNC_START;
					nxt_s.txd = 1'b0;
				end
			end
		end
		if (done_ev)
			nxt_s.done = 1'b1;
		if (done_ev || err_ev)
			nxt_s.irq = 1'b1;
		// Window read data follows the index
		if (s_ff.idx <= IDX_DATA_LAST)
			nxt_s.rdata = s_ff.data[s_ff.idx[2:0]];
		else
			case (s_ff.idx)
				IDX_CTRL: nxt_s.rdata = 8'(s_ff.txrx) << CTRL_TXRX_BIT;
				IDX_STATUS: nxt_s.rdata = status;
				IDX_SIZE: nxt_s.rdata = s_ff.size;
				IDX_DIV: nxt_s.rdata = s_ff.div_lo;
				IDX_MUL: nxt_s.rdata = s_ff.mul;
				IDX_ID: nxt_s.rdata = s_ff.id;
				default: nxt_s.rdata = REG_RESET;
			endcase
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_ff <= '0;
			s_ff.st <= LNC_IDLE;
			s_ff.txd <= 1'b1;
			s_ff.rx_prev <= 1'b1;
		end
		else
			s_ff <= nxt_s;
	end

	assign cfg_rdata = {s_ff.active, s_ff.master, s_ff.auto_rate, 5'h00};
	assign idx_rdata = s_ff.idx;
	assign win_rdata = s_ff.rdata;
	assign lin_tx = s_ff.txd;
	assign irq_req = s_ff.irq;
	assign busy = s_ff.st != LNC_IDLE;

	AST_MASTER: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_wr |=> cfg_rdata[CFG_MASTER_BIT] == $past(cfg_wdata[CFG_MASTER_BIT]))
		else $error("mode bit not taken");
	AST_AUTO: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_wr && cfg_wdata[CFG_AUTO_BIT] |=> s_ff.auto_rate && mult_eff == 5'h00)
		else $error("automatic rate ignores multiplier");
	AST_ACTIVE: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_wr && cfg_wdata[CFG_ACTIVE_BIT] |=> cfg_rdata[CFG_ACTIVE_BIT] [*3])
		else $error("interface not held active");
	AST_INDEX_READ: assert property (@(posedge clock) disable iff (sys_rst)
		idx_wr && idx_wdata == IDX_DIV ##1 !win_wr [*2] |-> win_rdata == s_ff.div_lo)
		else $error("window read does not follow index");
	AST_DIV_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
		win_wr && s_ff.idx == IDX_DIV |=> s_ff.div_lo == $past(win_wdata))
		else $error("divider low byte not written");
	AST_MUL_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
		win_wr && s_ff.idx == IDX_MUL |=>
		s_ff.mul[MUL_PRE_MSB:MUL_PRE_LSB] == $past(win_wdata[MUL_PRE_MSB:MUL_PRE_LSB]))
		else $error("prescale field not written");
	AST_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
		win_wr && s_ff.idx == IDX_CTRL && win_wdata == 8'h0c && !byte_done |=> !irq_req && !status[ST_ERR_BIT])
		else $error("clear did not drop flags");
	AST_RANGE: assert property (@(posedge clock) disable iff (sys_rst)
		s_ff.st == LNC_IDLE && s_ff.active && start_req && !factor_ok |=>
		s_ff.st == LNC_IDLE && s_ff.rng_err && irq_req)
		else $error("out of range factors started a frame");
	AST_TX_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
		s_ff.st == LNC_IDLE |-> lin_tx)
		else $error("bus not released while idle");
	AST_START_BIT: assert property (@(posedge clock) disable iff (sys_rst)
		s_ff.st == LNC_START && s_ff.dir_tx |-> !lin_tx)
		else $error("start bit not driven low");
	COV_TX_DONE: cover property (@(posedge clock) disable iff (sys_rst) s_ff.dir_tx && done_ev);
	COV_RX_DONE: cover property (@(posedge clock) disable iff (sys_rst) !s_ff.dir_tx && done_ev);
	COV_CS_ERR: cover property (@(posedge clock) disable iff (sys_rst) s_ff.cs_err && irq_req);
endmodule
`default_nettype wire

/* File: tb/lnc_peer.sv */
// Far-side bus node: decodes bytes from lin_tx and can send bytes on lin_rx.
// Assumes a fixed bit length of P system clocks and a pulled-up bus.
`timescale 1ns/1ps
`default_nettype none
module lnc_peer #(
	parameter int P = 1024
) (
	// Clock
	input wire logic clock,
	// Bus
	input wire logic lin_tx,
	output logic lin_rx,
	// Decoded bytes
	output logic got_valid,
	output logic [7:0] got_byte
);
	initial
	begin
		lin_rx = 1'b1;
		got_valid = 1'b0;
		got_byte = 8'h00;
	end
	// Sample each bit in its middle, least significant first
	always
	begin
		@(negedge lin_tx);
		repeat (P / 2) @(posedge clock);
		if (lin_tx === 1'b0)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (P) @(posedge clock);
				got_byte[i] = lin_tx;
			end
			repeat (P) @(posedge clock);
			#1 got_valid = 1'b1;
			@(posedge clock);
			#1 got_valid = 1'b0;
		end
	end
	// Start bit, eight data bits, stop bit; bus idles high
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			lin_rx = f[i];
			repeat (P) @(posedge clock);
			#1;
		end
	endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the node configuration and frame engine.
// Assumes the peer model on the bus and the design's own assertions.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lnc_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic cfg_wr = 1'b0;
	logic idx_wr = 1'b0;
	logic win_wr = 1'b0;
	logic [7:0] cfg_wdata = 8'h00;
	logic [7:0] idx_wdata = 8'h00;
	logic [7:0] win_wdata = 8'h00;
	logic [7:0] cfg_rdata;
	logic [7:0] idx_rdata;
	logic [7:0] win_rdata;
	logic lin_rx;
	logic lin_tx;
	logic irq_req;
	logic busy;
	logic got_valid;
	logic [7:0] got_byte;
	logic [31:0] seed = 32'h5a5a;
	logic [7:0] id_v;
	logic [7:0] d0;
	logic [7:0] exp_q[$];
	int n_mismatch = 0;
	int samples_checked = 0;
	always #50 clock = ~clock;
	lnc_top i_dut (.clock(clock), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .idx_wr(idx_wr), .idx_wdata(idx_wdata), .idx_rdata(idx_rdata),
		.win_wr(win_wr), .win_wdata(win_wdata), .win_rdata(win_rdata), .lin_rx(lin_rx),
		.lin_tx(lin_tx), .irq_req(irq_req), .busy(busy));
	lnc_peer #(.P(1024)) i_peer (.clock(clock), .lin_tx(lin_tx), .lin_rx(lin_rx),
		.got_valid(got_valid), .got_byte(got_byte));
	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		samples_checked++;
		if (seen !== expd)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	// Inverted sum with end-around carry
	function automatic logic [7:0] cksum(input logic [7:0] s0, input logic [7:0] d);
		logic [8:0] s;
		s = s0 + d;
		s = s[7:0] + s[8];
		return ~s[7:0];
	endfunction
	task automatic pulse(input int sel, input logic [7:0] d);
		@(posedge clock);
		#1;
		cfg_wr = (sel == 0);
		idx_wr = (sel == 1);
		win_wr = (sel == 2);
		cfg_wdata = d;
		idx_wdata = d;
		win_wdata = d;
		@(posedge clock);
		#1;
		cfg_wr = 1'b0;
		idx_wr = 1'b0;
		win_wr = 1'b0;
	endtask
	task automatic reg_w(input logic [7:0] idx, input logic [7:0] d);
		pulse(1, idx);
		pulse(2, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] expd);
		pulse(1, idx);
		repeat (2) @(posedge clock);
		#1;
		check(idx_rdata, idx);
		check(win_rdata, expd);
	endtask
	task automatic wait_irq();
		repeat (25000) if (irq_req !== 1'b1) @(posedge clock);
		#1;
		check(irq_req, 8'h01);
	endtask
	// Every decoded byte takes the oldest expectation
	always @(posedge clock)
	if (got_valid === 1'b1)
	begin
		check(got_byte, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
		check(lin_tx, 8'h01);
	end
	initial
	begin
		repeat (80000) @(posedge clock);
		n_mismatch++;
		stop_test();
	end
	initial
	begin
		repeat (4) @(posedge clock);
		#1 sys_rst = 1'b0;
		check(cfg_rdata, 8'h00);
		check(win_rdata, 8'h00);
		check({irq_req, busy, lin_tx}, 8'h01);
		pulse(0, 8'h80);
		pulse(0, 8'h40);
		check(cfg_rdata, 8'hc0);
		check(cfg_rdata, 8'hc0);
		// Manual rate in master mode: pre 0, mult 1, div 256, bit 1024 clocks
		reg_w(IDX_MUL, 8'h03);
		reg_w(IDX_DIV, 8'h00);
		rd(IDX_MUL, 8'h03);
		rd(IDX_DIV, 8'h00);
		reg_w(IDX_SIZE, 8'h81);
		rd(IDX_SIZE, 8'h81);
		id_v = rnd();
		d0 = rnd();
		reg_w(IDX_ID, id_v);
		reg_w(8'h00, d0);
		rd(8'h00, d0);
		reg_w(8'h0a, 8'h55);
		rd(8'h0a, 8'h00);
		exp_q.push_back(d0);
		exp_q.push_back(cksum(id_v, d0));
		reg_w(IDX_CTRL, 8'h21);
		check(busy, 8'h01);
		wait_irq();
		rd(IDX_STATUS, 8'h11);
		rd(IDX_CTRL, 8'h20);
		check(8'(exp_q.size()), 8'h00);
		reg_w(IDX_CTRL, 8'h0c);
		rd(IDX_STATUS, 8'h00);
		check(irq_req, 8'h00);
		// Receive one byte, classic checksum
		reg_w(IDX_SIZE, 8'h01);
		d0 = rnd();
		reg_w(IDX_CTRL, 8'h01);
		i_peer.send_byte(d0);
		i_peer.send_byte(cksum(8'h00, d0));
		wait_irq();
		rd(8'h00, d0);
		rd(IDX_STATUS, 8'h11);
		reg_w(IDX_CTRL, 8'h0c);
		// Divider 199 is below range and must be refused
		reg_w(IDX_MUL, 8'h02);
		reg_w(IDX_DIV, 8'hc7);
		reg_w(IDX_CTRL, 8'h21);
		wait_irq();
		check(busy, 8'h00);
		rd(IDX_STATUS, 8'h1c);
		reg_w(IDX_CTRL, 8'h0c);
		rd(IDX_STATUS, 8'h00);
		pulse(0, 8'h20);
		check(cfg_rdata, 8'ha0);
		stop_test();
	end
endmodule
`default_nettype wire
